// *** src/sps_phase_seq.sv ***
// stepper phase sequencer: position counter, pattern table, delay engine
// Notes on behaviour
// - each step request moves the position counter by one, direction chosen, or to 0 if it lies above the mode's top
// - full-step mode cycles the counter through 0 to 3
// - half-step mode cycles the counter through 0 to 7
// - counter indexes the pattern table; chosen pattern drives the bridge
// - next delay is previous minus twice previous over four times index plus one
// - first delay is the supplied square-root start value in timer ticks
// - step requests are served the cycle they arrive, never postponed
`timescale 1ns/10ps
module sps_phase_seq #(
   parameter int DELAY_W = sps_pkg::DELAY_W,
   parameter int INDEX_W = sps_pkg::INDEX_W
) (
   input  wire logic                    clock_i,
   input  wire logic                    reset_n_i,
   input  wire sps_pkg::sps_step_req_t  step_req_i,
   input  wire logic                    ramp_load_i,
   input  wire logic [DELAY_W-1:0]      ramp_c0_i,
   input  wire logic                    ramp_next_i,
   output sps_pkg::sps_drive_t          drive_o,
   output logic [sps_pkg::POS_W-1:0]    position_o,
   output logic [DELAY_W-1:0]           step_delay_o,
   output logic [INDEX_W-1:0]           ramp_index_o,
   output logic                         ramp_busy_o
);
   if (DELAY_W < 4 || DELAY_W > 61 || INDEX_W < 2) begin : g_bad_width
      $error("sps_phase_seq: widths out of range");
   end

   logic [sps_pkg::POS_W-1:0] position, next_position;
   sps_pkg::sps_drive_t       drive, next_drive;
   logic                      half_mode, next_half_mode;

   function automatic logic [sps_pkg::POS_W-1:0] top_of(input logic half);
      top_of = half ? sps_pkg::POS_HALF_MAX : sps_pkg::POS_FULL_MAX;
   endfunction : top_of

   // half-step table; full-step uses the single-coil entries (even slots)
   function automatic sps_pkg::sps_drive_t pattern_of(input logic [sps_pkg::POS_W-1:0] pos,
                                                      input logic half);
      logic [sps_pkg::POS_W-1:0] slot;
      slot = half ? pos : {pos[1:0], 1'b0};
      unique case (slot)
         3'h0: pattern_of = 4'h8;
         3'h1: pattern_of = 4'hA;
         3'h2: pattern_of = 4'h2;
         3'h3: pattern_of = 4'h6;
         3'h4: pattern_of = 4'h4;
         3'h5: pattern_of = 4'h5;
         3'h6: pattern_of = 4'h1;
         3'h7: pattern_of = 4'h9;
      endcase
   endfunction : pattern_of

   always_comb begin
      logic [sps_pkg::POS_W-1:0] top;
      top            = top_of(step_req_i.half_mode);
      next_position  = position;
      next_half_mode = half_mode;
      // request handled the cycle it arrives, no arbitration stage
      if (step_req_i.valid) begin
         next_half_mode = step_req_i.half_mode;
         if (position > top)
            next_position = sps_pkg::POS_RESET;
         else if (step_req_i.dir_up)
            next_position = (position == top) ? sps_pkg::POS_RESET : position + 3'h1;
         else
            next_position = (position == sps_pkg::POS_RESET) ? top : position - 3'h1;
      end
      next_drive = pattern_of(next_position, next_half_mode);
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         position  <= sps_pkg::POS_RESET;
         half_mode <= 1'b0;
         drive     <= sps_pkg::DRIVE_IDLE;
      end else begin
         position  <= next_position;
         half_mode <= next_half_mode;
         drive     <= next_drive;
      end
   end

   logic [DELAY_W-1:0] calc_delay;
   logic [INDEX_W-1:0] calc_index;
   logic               calc_busy;

   // ramp controller only issues a request on timer expiry, so delay is ready by then
   sps_delay_calc #(
      .DELAY_W (DELAY_W),
      .INDEX_W (INDEX_W)
   ) u_delay (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .load_i    (ramp_load_i),
      .c0_i      (ramp_c0_i),
      .next_i    (ramp_next_i),
      .delay_o   (calc_delay),
      .index_o   (calc_index),
      .busy_o    (calc_busy)
   );

   logic [DELAY_W-1:0] delay_q;
   logic [INDEX_W-1:0] index_q;
   logic               busy_q;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         delay_q <= sps_pkg::DELAY_RESET;
         index_q <= sps_pkg::INDEX_RESET;
         busy_q  <= 1'b0;
      end else begin
         delay_q <= calc_delay;
         index_q <= calc_index;
         busy_q  <= calc_busy;
      end
   end

   assign drive_o      = drive;
   assign position_o   = position;
   assign step_delay_o = delay_q;
   assign ramp_index_o = index_q;
   assign ramp_busy_o  = busy_q;

   sequence s_up_step;
      step_req_i.valid && step_req_i.dir_up && position <= top_of(step_req_i.half_mode);
   endsequence
   sequence s_down_step;
      step_req_i.valid && !step_req_i.dir_up && position <= top_of(step_req_i.half_mode);
   endsequence

   chk_step_up: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_up_step |=> position == (($past(position) == top_of($past(step_req_i.half_mode)))
                                 ? sps_pkg::POS_RESET : $past(position) + 3'h1))
      else $error("position did not advance by one");
   chk_step_down: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      s_down_step |=> position == (($past(position) == sps_pkg::POS_RESET)
                                   ? top_of($past(step_req_i.half_mode)) : $past(position) - 3'h1))
      else $error("position did not retreat by one");
   chk_full_range: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (step_req_i.valid && !step_req_i.half_mode) |=> position <= sps_pkg::POS_FULL_MAX)
      else $error("full-step position out of range");
   chk_half_wrap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (step_req_i.valid && step_req_i.half_mode && step_req_i.dir_up && position == sps_pkg::POS_HALF_MAX)
      |=> position == sps_pkg::POS_RESET)
      else $error("half-step did not wrap after seven");
   chk_drive_table: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      step_req_i.valid |=> drive == pattern_of(position, half_mode)
                           && !(drive.a_pos && drive.a_neg) && !(drive.b_pos && drive.b_neg))
      else $error("drive pattern does not match position");
   chk_hold_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !step_req_i.valid |=> $stable(position))
      else $error("position moved without a request");
endmodule : sps_phase_seq

// *** shared/sps_pkg.sv ***
// shared types and constants for the stepper phase sequencer
package sps_pkg;
   localparam int POS_W = 3;
   localparam logic [POS_W-1:0] POS_FULL_MAX = 3'h3;
   localparam logic [POS_W-1:0] POS_HALF_MAX = 3'h7;
   localparam logic [POS_W-1:0] POS_RESET = 3'h0;
   localparam logic [3:0] DRIVE_IDLE = 4'h0;
   localparam int DELAY_W = 24;
   localparam int INDEX_W = 16;
   localparam logic [INDEX_W-1:0] INDEX_RESET = 16'h0000;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 24'h000000;
   localparam logic [DELAY_W-1:0] DELAY_MIN = 24'h000001;
   localparam int DIV_STEPS = DELAY_W + 2;
   localparam logic [1:0] STEP_MUL = 2'h2;
   localparam logic [2:0] INDEX_MUL = 3'h4;

   // winding drive to the bridge: coil a and b, each with its two bridge halves
   typedef struct packed {
      logic a_pos;
      logic a_neg;
      logic b_pos;
      logic b_neg;
   } sps_drive_t;

   typedef struct packed {
      logic valid;
      logic dir_up;
      logic half_mode;
   } sps_step_req_t;

   typedef enum logic [2:0] {
      SPS_DIV_IDLE = 3'b001,
      SPS_DIV_RUN  = 3'b010,
      SPS_DIV_DONE = 3'b100
   } sps_div_state_t;
endpackage : sps_pkg

// *** src/sps_delay_calc.sv ***
// inter-step delay recurrence engine with carried remainder
`timescale 1ns/10ps
module sps_delay_calc #(
   parameter int DELAY_W = sps_pkg::DELAY_W,
   parameter int INDEX_W = sps_pkg::INDEX_W
) (
   input  wire logic               clock_i,
   input  wire logic               reset_n_i,
   input  wire logic               load_i,
   input  wire logic [DELAY_W-1:0] c0_i,
   input  wire logic               next_i,
   output logic [DELAY_W-1:0]      delay_o,
   output logic [INDEX_W-1:0]      index_o,
   output logic                    busy_o
);
   localparam int NUM_W   = DELAY_W + 2;
   localparam int DEN_W   = INDEX_W + 3;
   // one divide cycle per numerator bit, then the done cycle
   localparam int DIV_LAT = NUM_W + 1;

   // six-bit bit counter caps the numerator width
   if (DELAY_W < 4 || DELAY_W > 61 || INDEX_W < 2) begin : g_bad_width
      $error("sps_delay_calc: widths out of range");
   end

   sps_pkg::sps_div_state_t state, next_state;
   logic [DELAY_W-1:0] delay, next_delay;
   logic [INDEX_W-1:0] index, next_index;
   logic [NUM_W-1:0]   rem, next_rem;
   logic [NUM_W-1:0]   quo, next_quo;
   logic [NUM_W-1:0]   work, next_work;
   logic [DEN_W-1:0]   den, next_den;
   logic [NUM_W-1:0]   carry, next_carry;
   logic [5:0]         cnt, next_cnt;

   // serial divide: one quotient bit per clock keeps the step path small
   always_comb begin
      logic [NUM_W:0] trial;
      trial      = '0;
      next_state = state;
      next_delay = delay;
      next_index = index;
      next_rem   = rem;
      next_quo   = quo;
      next_work  = work;
      next_den   = den;
      next_carry = carry;
      next_cnt   = cnt;
      unique case (state)
         sps_pkg::SPS_DIV_IDLE: begin
            if (load_i) begin
               next_delay = c0_i;
               next_index = sps_pkg::INDEX_RESET;
               next_carry = '0;
            end else if (next_i) begin
               next_index = index + INDEX_W'(1);
               next_work  = NUM_W'(sps_pkg::STEP_MUL) * NUM_W'(delay) + carry;
               next_den   = DEN_W'(sps_pkg::INDEX_MUL) * DEN_W'(index + INDEX_W'(1)) + DEN_W'(1);
               next_rem   = '0;
               next_quo   = '0;
               next_cnt   = 6'(NUM_W);
               next_state = sps_pkg::SPS_DIV_RUN;
            end
         end
         sps_pkg::SPS_DIV_RUN: begin
            trial     = {rem, work[NUM_W-1]};
            next_work = {work[NUM_W-2:0], 1'b0};
            if (trial >= (NUM_W+1)'(den)) begin
               next_rem = NUM_W'(trial - (NUM_W+1)'(den));
               next_quo = {quo[NUM_W-2:0], 1'b1};
            end else begin
               next_rem = trial[NUM_W-1:0];
               next_quo = {quo[NUM_W-2:0], 1'b0};
            end
            next_cnt = cnt - 6'h01;
            if (cnt == 6'h01) next_state = sps_pkg::SPS_DIV_DONE;
         end
         sps_pkg::SPS_DIV_DONE: begin
            // floor at one tick so the step timer never stalls
            if (NUM_W'(delay) > quo && NUM_W'(delay) - quo >= NUM_W'(sps_pkg::DELAY_MIN))
               next_delay = DELAY_W'(NUM_W'(delay) - quo);
            else
               next_delay = sps_pkg::DELAY_MIN;
            next_carry = rem;
            next_state = sps_pkg::SPS_DIV_IDLE;
         end
         default: next_state = sps_pkg::SPS_DIV_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= sps_pkg::SPS_DIV_IDLE;
         delay <= sps_pkg::DELAY_RESET;
         index <= sps_pkg::INDEX_RESET;
         rem   <= '0;
         quo   <= '0;
         work  <= '0;
         den   <= '0;
         carry <= '0;
         cnt   <= '0;
      end else begin
         state <= next_state;
         delay <= next_delay;
         index <= next_index;
         rem   <= next_rem;
         quo   <= next_quo;
         work  <= next_work;
         den   <= next_den;
         carry <= next_carry;
         cnt   <= next_cnt;
      end
   end

   assign delay_o = delay;
   assign index_o = index;
   assign busy_o  = (state != sps_pkg::SPS_DIV_IDLE);

   chk_div_bounded: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state == sps_pkg::SPS_DIV_IDLE && !load_i && next_i) |-> ##[DIV_LAT:DIV_LAT] (state == sps_pkg::SPS_DIV_DONE))
      else $error("delay divide did not finish in time");
   chk_delay_shrinks: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state == sps_pkg::SPS_DIV_DONE && delay > sps_pkg::DELAY_MIN && quo != '0) |=> (delay < $past(delay)))
      else $error("delay did not decrease after step");
   chk_load_c0: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state == sps_pkg::SPS_DIV_IDLE && load_i) |=> (delay == $past(c0_i) && index == sps_pkg::INDEX_RESET))
      else $error("initial delay not loaded");
endmodule : sps_delay_calc

// *** dv/sps_bridge_model.sv ***
// behavioural power bridge driven by the winding pattern
`timescale 1ns/10ps
module sps_bridge_model (
   input  wire logic                clock_i,
   input  wire sps_pkg::sps_drive_t drive_i,
   output logic [1:0]               coil_a_o,
   output logic [1:0]               coil_b_o,
   output logic                     shoot_through_o
);
   // both halves of one coil on would short the supply rail
   always_ff @(posedge clock_i) begin
      coil_a_o        <= {drive_i.a_pos, drive_i.a_neg};
      coil_b_o        <= {drive_i.b_pos, drive_i.b_neg};
      shoot_through_o <= (drive_i.a_pos & drive_i.a_neg) | (drive_i.b_pos & drive_i.b_neg);
   end
endmodule : sps_bridge_model

// *** dv/tb_sps_phase_seq.sv ***
// self-checking bench for the stepper phase sequencer
`timescale 1ns/10ps
module tb_sps_phase_seq;
   logic                   clock_i     = 1'b0;
   logic                   reset_n_i   = 1'b0;
   sps_pkg::sps_step_req_t step_req_i  = '0;
   logic                   ramp_load_i = 1'b0;
   logic [23:0]            ramp_c0_i   = 24'h000000;
   logic                   ramp_next_i = 1'b0;
   sps_pkg::sps_drive_t    drive_o;
   logic [2:0]             position_o;
   logic [23:0]            step_delay_o;
   logic [15:0]            ramp_index_o;
   logic                   ramp_busy_o;
   logic [1:0]             coil_a;
   logic [1:0]             coil_b;
   logic                   shoot_through;
   logic [2:0]             exp_pos = 3'h0;
   int                     mismatches = 0;
   int                     samples_checked = 0;
   localparam logic [3:0] FULL_TAB [4] = '{4'h8, 4'h2, 4'h4, 4'h1};
   localparam logic [3:0] HALF_TAB [8] = '{4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9};

   always #25 clock_i = ~clock_i;

   sps_phase_seq DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .step_req_i(step_req_i),
      .ramp_load_i(ramp_load_i), .ramp_c0_i(ramp_c0_i), .ramp_next_i(ramp_next_i), .drive_o(drive_o),
      .position_o(position_o), .step_delay_o(step_delay_o), .ramp_index_o(ramp_index_o),
      .ramp_busy_o(ramp_busy_o));

   sps_bridge_model bridge (.clock_i(clock_i), .drive_i(drive_o), .coil_a_o(coil_a), .coil_b_o(coil_b),
      .shoot_through_o(shoot_through));

   task automatic compare(input logic [23:0] got, input logic [23:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : compare

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // reset lands asynchronously, so outputs are looked at while it is held
   task automatic reset_test();
      @(negedge clock_i);
      reset_n_i = 1'b0;
      repeat (2) @(negedge clock_i);
      compare({21'h0, position_o}, 24'h0, "reset position");
      compare({20'h0, drive_o}, 24'h0, "reset drive");
      compare(step_delay_o, 24'h0, "reset delay");
      compare({8'h00, ramp_index_o}, 24'h0, "reset index");
      compare({23'h0, ramp_busy_o}, 24'h0, "reset busy");
      reset_n_i = 1'b1;
      exp_pos = 3'h0;
      $display("reset test done");
   endtask : reset_test

   // requests held high on consecutive edges, so every step is back to back
   task automatic step_run(input logic up, input logic half, input int n);
      logic [2:0] top;
      top = half ? 3'h7 : 3'h3;
      for (int i = 0; i <= n; i++) begin
         @(negedge clock_i);
         if (i > 0) begin
            compare({21'h0, position_o}, {21'h0, exp_pos}, "position");
            compare({20'h0, drive_o}, {20'h0, half ? HALF_TAB[exp_pos] : FULL_TAB[exp_pos]}, "drive");
            compare({23'h0, shoot_through}, 24'h0, "bridge short");
         end
         step_req_i = '{valid: (i < n), dir_up: up, half_mode: half};
         if (i < n && exp_pos > top) begin
            exp_pos = 3'h0; // left over from half-step, cycle restarts
         end else if (i < n) begin
            exp_pos = up ? ((exp_pos == top) ? 3'h0 : exp_pos + 3'h1) : ((exp_pos == 3'h0) ? top : exp_pos - 3'h1);
         end
      end
      @(negedge clock_i);
      compare({20'h0, coil_a, coil_b}, {20'h0, half ? HALF_TAB[exp_pos] : FULL_TAB[exp_pos]}, "coils");
      $display("step test up=%0b half=%0b done", up, half);
   endtask : step_run

   // two nexts per step: the first after the engine went idle, the second while it is still busy
   task automatic ramp_test();
      logic [23:0] c;
      logic [23:0] rest;
      logic [23:0] num;
      logic [23:0] div;
      c = 24'h0003E8;
      rest = 24'h000000;
      @(negedge clock_i);
      ramp_c0_i = c;
      ramp_load_i = 1'b1;
      @(negedge clock_i);
      ramp_load_i = 1'b0;
      repeat (2) @(negedge clock_i);
      compare(step_delay_o, c, "start delay");
      compare({8'h00, ramp_index_o}, 24'h0, "start index");
      for (int n = 1; n <= 4; n++) begin
         num = 24'h000002 * c + rest;
         div = 24'(4 * n + 1);
         rest = num % div;
         c = (num / div >= c) ? 24'h000001 : c - num / div;
         ramp_next_i = 1'b1;
         @(negedge clock_i);
         ramp_next_i = 1'b0;
         @(negedge clock_i);
         compare({23'h0, ramp_busy_o}, 24'h000001, "busy raised");
         // a request while busy is dropped, so the index moves once only
         ramp_next_i = 1'b1;
         @(negedge clock_i);
         ramp_next_i = 1'b0;
         for (int k = 0; k < 80 && (k < 4 || ramp_busy_o !== 1'b0); k++) @(negedge clock_i);
         @(negedge clock_i);
         compare({23'h0, ramp_busy_o}, 24'h0, "busy");
         compare(step_delay_o, c, "next delay");
         compare({8'h00, ramp_index_o}, 24'(n), "next index");
      end
      $display("ramp test done");
   endtask : ramp_test

   initial begin
      #250000;
      mismatches++;
      $display("BAD t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      reset_test();
      step_run(1'b1, 1'b0, 5);
      step_run(1'b0, 1'b0, 6);
      step_run(1'b1, 1'b1, 9);
      step_run(1'b0, 1'b1, 10);
      step_run(1'b1, 1'b1, 3);
      step_run(1'b1, 1'b0, 2);
      ramp_test();
      reset_test();
      step_run(1'b0, 1'b1, 1);
      tally_and_finish();
   end
endmodule : tb_sps_phase_seq
